/* File: shared/swsc_pkg.sv */
// constants and types for the switch scan and shutdown controller
package swsc_pkg;

  // time base: one tick per microsecond
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned US_PER_MS     = 1000;
  localparam logic [4:0]  TICK_CYC      = 5'(TICK_NS / CLK_PERIOD_NS);

  // timing figures in their own units
  localparam int unsigned POLL_TIME_US  = 250;
  localparam int unsigned EXIT_TIME_US  = 200;
  localparam int unsigned WET_LIMIT_MS  = 20;
  localparam int unsigned PERIOD_MIN_MS = 2;

  // the same figures as tick counts
  localparam logic [16:0] POLL_TICKS        = 17'(POLL_TIME_US);
  localparam logic [7:0]  EXIT_TICKS        = 8'(EXIT_TIME_US);
  localparam logic [14:0] WET_LIMIT_TICKS   = 15'(WET_LIMIT_MS * US_PER_MS);
  localparam logic [16:0] PERIOD_BASE_TICKS = 17'(PERIOD_MIN_MS * US_PER_MS);

  // scanning-period codes
  localparam logic [2:0] SCAN_CODE_MAX  = 3'h5;
  localparam logic [2:0] SCAN_CONT_HYST = 3'h6;
  localparam logic [2:0] SCAN_CONT      = 3'h7;

  // command register field layout, bit 15 down to bit 0
  typedef struct packed {
    logic       wetting_continuous_sel;
    logic [2:0] scan_period;
    logic       wetting_global_en;
    logic       low_pair_wetting_en;
    logic [1:0] group_battery_sel;
    logic [7:0] irq_disable;
  } swsc_cmd_type;

  localparam swsc_cmd_type CMD_RESET = 16'h0000;

  // gray order: shutdown, wake, scan, normal
  typedef enum logic [1:0] {
    ST_SHDN   = 2'h0,
    ST_WAKE   = 2'h1,
    ST_SCAN   = 2'h3,
    ST_NORMAL = 2'h2
  } swsc_mode_type;

endpackage

/* File: src/swsc_tick.sv */
// microsecond tick generator shared by all timers
`timescale 1ns/1ps
`default_nettype none

module swsc_tick (
  // clock and control
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // one-cycle tick every microsecond
  output logic      tick_o
);
  import swsc_pkg::*;

  logic [4:0] div_q;
  logic [4:0] div_d;
  logic       tick_d;

  always_comb begin
    tick_d = (div_q == TICK_CYC - 5'h01);
    div_d  = tick_d ? 5'h00 : div_q + 5'h01;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      div_q  <= 5'h00;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      div_q  <= div_d;
      tick_o <= tick_d;
    end
  end

endmodule

`default_nettype wire

/* File: src/swsc_scan_ctrl.sv */
// scan-mode polling, wetting pulses and shutdown sequencing of a switch monitor
`timescale 1ns/1ps
`default_nettype none

module swsc_scan_ctrl #(
  parameter logic [16:0] POLL_US        = swsc_pkg::POLL_TICKS,
  parameter logic [7:0]  EXIT_US        = swsc_pkg::EXIT_TICKS,
  parameter logic [14:0] WET_LIMIT_US   = swsc_pkg::WET_LIMIT_TICKS,
  parameter logic [16:0] PERIOD_BASE_US = swsc_pkg::PERIOD_BASE_TICKS
) (
  // clock and control
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  // command register load from the serial logic
  input  wire logic                   cmd_wr_i,
  input  wire swsc_pkg::swsc_cmd_type cmd_data_i,
  // pins
  input  wire logic                   shutdown_n_i,
  input  wire logic [7:0]             switch_level_i,
  // switch front end
  output logic [7:0]                  sense_conn_o,
  output logic [7:0]                  wet_drive_o,
  output logic                        input_hiz_o,
  output logic                        direct_out_a_o,
  output logic                        direct_out_a_oe_o,
  output logic                        direct_out_b_o,
  output logic                        direct_out_b_oe_o,
  // status
  output logic [7:0]                  sw_state_o,
  output var swsc_pkg::swsc_mode_type mode_o,
  output var swsc_pkg::swsc_cmd_type  cmd_o
);
  import swsc_pkg::*;

  logic          tick;
  logic          sd_meta_q;
  logic          sd_sync_q;
  logic [7:0]    sw_meta_q;
  logic [7:0]    sw_sync_q;
  swsc_mode_type state_q;
  swsc_mode_type state_d;
  swsc_cmd_type  cmd_q;
  swsc_cmd_type  cmd_d;
  logic [7:0]    exit_cnt_q;
  logic [7:0]    exit_cnt_d;
  logic [16:0]   per_cnt_q;
  logic [16:0]   per_cnt_d;
  logic [16:0]   period_len;
  logic [2:0]    shamt;
  logic          poll;
  logic          poll_end;
  logic          sensing;
  logic [7:0]    sense_mask;
  logic [7:0]    wet_mask;
  logic [7:0]    wet_expired;
  logic [7:0]    sw_state_d;
  logic [7:0]    sense_d;
  logic [7:0]    wet_d;
  logic          hiz_d;
  logic          direct_oe_d;

  swsc_tick u_tick (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .tick_o    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sd_meta_q <= 1'b1;
      sd_sync_q <= 1'b1;
      sw_meta_q <= 8'h00;
      sw_sync_q <= 8'h00;
    end else if (ce_i) begin
      sd_meta_q <= shutdown_n_i;
      sd_sync_q <= sd_meta_q;
      sw_meta_q <= switch_level_i;
      sw_sync_q <= sw_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode, command register, exit delay
  always_comb begin
    state_d    = state_q;
    exit_cnt_d = 8'h00;
    cmd_d      = cmd_q;
    unique case (state_q)
      ST_SHDN: begin
        if (sd_sync_q) state_d = ST_WAKE;
      end
      ST_WAKE: begin
        exit_cnt_d = exit_cnt_q + {7'h00, tick};
        if (tick && exit_cnt_q == EXIT_US - 8'h01) state_d = ST_SCAN;
      end
      ST_SCAN, ST_NORMAL: begin
        state_d = (cmd_q.scan_period > SCAN_CODE_MAX) ? ST_NORMAL : ST_SCAN;
      end
    endcase
    if (!sd_sync_q) state_d = ST_SHDN;
    if (state_q == ST_SHDN || state_q == ST_WAKE || !sd_sync_q) cmd_d = CMD_RESET;
    else if (cmd_wr_i) cmd_d = cmd_data_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q    <= ST_SCAN;
      cmd_q      <= CMD_RESET;
      exit_cnt_q <= 8'h00;
    end else if (ce_i) begin
      state_q    <= state_d;
      cmd_q      <= cmd_d;
      exit_cnt_q <= exit_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scan period and polling window
  always_comb begin
    shamt      = SCAN_CODE_MAX - cmd_q.scan_period;
    period_len = PERIOD_BASE_US << shamt;
    per_cnt_d  = 17'h00000;
    if (state_q == ST_SCAN) begin
      per_cnt_d = per_cnt_q;
      // >= keeps the count sane when software shortens the period
      if (tick) per_cnt_d = (per_cnt_q >= period_len - 17'h00001) ? 17'h00000
                                                                   : per_cnt_q + 17'h00001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) per_cnt_q <= 17'h00000;
    else if (ce_i) per_cnt_q <= per_cnt_d;
  end

  // window at the start of each period
  assign poll     = (state_q == ST_SCAN) && (per_cnt_q < POLL_US);
  assign poll_end = poll && tick && (per_cnt_q == POLL_US - 17'h00001);
  assign sensing  = poll || (state_q == ST_NORMAL);
  // direct-input pair loses its resistors and wetting
  assign sense_mask = {6'h3f, {2{cmd_q.low_pair_wetting_en}}};
  assign wet_mask   = {{6{cmd_q.wetting_global_en}},
                       {2{cmd_q.wetting_global_en & cmd_q.low_pair_wetting_en}}};

  ////////////////////////////////////////////////////////////////////////////
  // per-channel wetting limit timers
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_wet
      logic [14:0] tmr_q;
      logic [14:0] tmr_d;
      always_comb begin
        wet_expired[gi] = (tmr_q == WET_LIMIT_US);
        tmr_d = tmr_q;
        if (!sw_state_o[gi]) tmr_d = 15'h0000;
        else if (tick && !wet_expired[gi]) tmr_d = tmr_q + 15'h0001;
      end
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) tmr_q <= 15'h0000;
        else if (ce_i) tmr_q <= tmr_d;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // front-end drive and sampled state
  always_comb begin
    // one common connect for every input in sense_mask
    sense_d = sensing ? sense_mask : 8'h00;
    // wetting only while sensing a closed switch
    wet_d = (sensing ? wet_mask : 8'h00) & sw_state_o &
            ({8{cmd_q.wetting_continuous_sel}} | ~wet_expired);
    hiz_d = (state_q == ST_SHDN) || (state_q == ST_WAKE);
    // direct pair only in normal mode
    direct_oe_d = (state_q == ST_NORMAL) && !cmd_q.low_pair_wetting_en;
    sw_state_d  = sw_state_o;
    unique case (state_q)
      ST_SHDN, ST_WAKE: sw_state_d = 8'h00;
      ST_NORMAL:        sw_state_d = sw_sync_q & sense_mask;
      // every input in sense_mask latched at the same window end
      ST_SCAN:          if (poll_end) sw_state_d = sw_sync_q & sense_mask;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sense_conn_o      <= 8'h00;
      wet_drive_o       <= 8'h00;
      input_hiz_o       <= 1'b0;
      direct_out_a_o    <= 1'b0;
      direct_out_a_oe_o <= 1'b0;
      direct_out_b_o    <= 1'b0;
      direct_out_b_oe_o <= 1'b0;
      sw_state_o        <= 8'h00;
      mode_o            <= ST_SCAN;
      cmd_o             <= CMD_RESET;
    end else if (ce_i) begin
      sense_conn_o      <= sense_d;
      wet_drive_o       <= wet_d;
      input_hiz_o       <= hiz_d;
      direct_out_a_o    <= sw_sync_q[0];
      direct_out_a_oe_o <= direct_oe_d;
      direct_out_b_o    <= sw_sync_q[1];
      direct_out_b_oe_o <= direct_oe_d;
      sw_state_o        <= sw_state_d;
      mode_o            <= state_d;
      cmd_o             <= cmd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  a_sense_idle_off: assert property (
    state_q == ST_SCAN && !poll && state_d == ST_SCAN |=> sense_conn_o == 8'h00)
    else $error("sense resistors connected outside window");
  a_sense_all_on: assert property (
    poll && state_d == ST_SCAN |=> sense_conn_o == $past(sense_mask))
    else $error("sense resistors not connected together");
  a_wet_in_window: assert property (
    state_q == ST_SCAN && !poll |=> wet_drive_o == 8'h00)
    else $error("wetting current outside window");
  a_wet_limit_stop: assert property (
    wet_expired[2] && !cmd_q.wetting_continuous_sel |=> !wet_drive_o[2])
    else $error("wetting pulse after limit");
  a_wet_cont_run: assert property (
    state_q == ST_NORMAL && state_d == ST_NORMAL && cmd_q.wetting_continuous_sel
    && wet_mask[2] && sw_state_o[2] |=> wet_drive_o[2])
    else $error("continuous wetting missing");
  a_direct_hiz_scan: assert property (
    state_q == ST_SCAN |=> !direct_out_a_oe_o && !direct_out_b_oe_o)
    else $error("direct output driven in scan mode");
  a_shdn_float: assert property (
    !sd_sync_q |-> ##2 input_hiz_o && sense_conn_o == 8'h00 && wet_drive_o == 8'h00
    && sw_state_o == 8'h00)
    else $error("inputs active in shutdown");
  a_shdn_clear: assert property (
    !sd_sync_q |=> cmd_q == CMD_RESET && state_q == ST_SHDN)
    else $error("command kept through shutdown");
  a_exit_delay: assert property (
    state_q == ST_SHDN && sd_sync_q |=> state_q == ST_WAKE [*8])
    else $error("shutdown exit too early");
  a_exit_bound: assert property (state_q == ST_WAKE |-> exit_cnt_q < EXIT_US)
    else $error("shutdown exit overran its delay");
  a_cmd_kept: assert property (
    sd_sync_q && state_q == ST_SCAN && !cmd_wr_i |=> $stable(cmd_q))
    else $error("command register changed without write");
  a_period_wrap: assert property (
    state_q == ST_SCAN && state_d == ST_SCAN && tick
    && per_cnt_q == period_len - 17'h00001 |=> per_cnt_q == 17'h00000)
    else $error("scan period length wrong");
  a_mode_code: assert property (
    state_q == ST_NORMAL |-> $past(cmd_q.scan_period) >= SCAN_CONT_HYST)
    else $error("normal mode on periodic code");
  a_count_on_tick: assert property (
    state_q == ST_SCAN && $past(state_q) == ST_SCAN && per_cnt_q != $past(per_cnt_q)
    |-> $past(tick))
    else $error("period counter moved without tick");

  c_poll_window: cover property (poll_end);
  c_shdn_exit: cover property (state_q == ST_WAKE ##1 state_q == ST_SCAN);
  c_normal_mode: cover property (state_q == ST_SCAN ##1 state_q == ST_NORMAL);
  c_wet_expire: cover property (wet_drive_o[2] ##1 wet_expired[2]);

endmodule

`default_nettype wire

/* File: dv/swsc_switch_model.sv */
// partner model: switch contacts and the host driving the shutdown pin
`timescale 1ns/1ps
`default_nettype none

module swsc_switch_model (
  // clock and bench stimulus
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] closed_i,
  input  wire logic       sleep_i,
  // device front end
  input  wire logic [7:0] sense_i,
  input  wire logic [1:0] direct_oe_i,
  // pins
  output logic [7:0]      level_o,
  output logic            shutdown_n_o
);
  logic [7:0] read_mask;

  assign read_mask = sense_i | {6'h00, direct_oe_i};

  initial begin
    level_o = 8'h00;
    shutdown_n_o = 1'b1;
  end

  // unread inputs toggle so a stale level never passes as a reading
  always @(posedge sys_clk_i) begin
    level_o <= (read_mask & closed_i) | (~read_mask & ~level_o);
  end

  always @(posedge sys_clk_i) begin
    shutdown_n_o <= !sleep_i;
  end
endmodule

`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the switch scan and shutdown controller
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import swsc_pkg::*;

  typedef struct packed {
    logic          win;
    logic [31:0]   per;
    swsc_mode_type mode;
    logic [2:0]    dout;
    logic          hiz;
    logic [7:0]    sense;
    logic [7:0]    wet;
    logic [7:0]    sw;
    swsc_cmd_type  cmd;
  } swsc_note_type;

  // short counts keep the run small
  localparam logic [16:0] POLL = 17'h00004;
  localparam logic [7:0]  EXIT = 8'h03;
  localparam logic [16:0] BASE = 17'h00008;
  localparam int          TK   = 25;

  logic          sys_clk_i;
  logic          rst_i      = 1'b1;
  logic          cmd_wr_i   = 1'b0;
  swsc_cmd_type  cmd_data_i = CMD_RESET;
  swsc_cmd_type  cmd_now    = CMD_RESET;
  swsc_cmd_type  cmd;
  logic [7:0]    closed     = 8'h00;
  logic          sleep      = 1'b0;
  logic          shutdown_n, input_hiz_o, oe_a, oe_b, out_a, out_b;
  logic [7:0]    level, sense_conn_o, wet_drive_o, sw_state_o, sense_q, sense_acc, wet_acc;
  swsc_mode_type mode_o;
  swsc_cmd_type  cmd_o;
  swsc_note_type q[$];
  swsc_note_type n;
  int            failures = 0;
  int            compares = 0;
  int            seed     = 7096;
  int            cyc      = 0;
  int            t_rise   = 0;
  int            per      = 0;
  int            len;

  swsc_scan_ctrl #(
    .POLL_US        (POLL),
    .EXIT_US        (EXIT),
    .WET_LIMIT_US   (15'h0014),
    .PERIOD_BASE_US (BASE)
  ) i_swsc_scan_ctrl (
    .sys_clk_i         (sys_clk_i),
    .rst_i             (rst_i),
    .ce_i              (1'b1),
    .cmd_wr_i          (cmd_wr_i),
    .cmd_data_i        (cmd_data_i),
    .shutdown_n_i      (shutdown_n),
    .switch_level_i    (level),
    .sense_conn_o      (sense_conn_o),
    .wet_drive_o       (wet_drive_o),
    .input_hiz_o       (input_hiz_o),
    .direct_out_a_o    (out_a),
    .direct_out_a_oe_o (oe_a),
    .direct_out_b_o    (out_b),
    .direct_out_b_oe_o (oe_b),
    .sw_state_o        (sw_state_o),
    .mode_o            (mode_o),
    .cmd_o             (cmd_o)
  );

  swsc_switch_model i_swsc_switch_model (
    .sys_clk_i    (sys_clk_i),
    .closed_i     (closed),
    .sleep_i      (sleep),
    .sense_i      (sense_conn_o),
    .direct_oe_i  ({oe_b, oe_a}),
    .level_o      (level),
    .shutdown_n_o (shutdown_n)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wr(input swsc_cmd_type c);
    cmd_data_i <= c;
    cmd_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    cmd_wr_i <= 1'b0;
    cmd_now = c;
    @(posedge sys_clk_i);
  endtask

  // bounded waits for k polling windows to close
  task automatic falls(input int k);
    int w;
    repeat (k) begin
      for (w = 0; w < 9000 && sense_conn_o === 8'h00; w++) @(posedge sys_clk_i);
      for (w = 0; w < 300 && sense_conn_o !== 8'h00; w++) @(posedge sys_clk_i);
    end
  endtask

  task automatic note(input logic w, input logic [31:0] p, input swsc_mode_type m,
                      input logic [2:0] d, input logic h, input logic [7:0] s,
                      input logic [7:0] wt);
    logic [7:0] swx;
    swx = h ? 8'h00 : closed & {6'h3f, {2{cmd_now.low_pair_wetting_en}}};
    q.push_back('{w, p, m, d, h, s, wt, swx, cmd_now});
    while (q.size() > 0) @(posedge sys_clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watcher: a closing window or a snapshot settles the oldest note
  initial begin
    sense_q = 8'h00;
    forever begin
      @(posedge sys_clk_i);
      #1;
      cyc++;
      if (sense_conn_o !== 8'h00 && sense_q === 8'h00) begin
        per = cyc - t_rise;
        t_rise = cyc;
        sense_acc = sense_conn_o;
        wet_acc = 8'h00;
      end
      wet_acc |= wet_drive_o;
      if (q.size() > 0 && (!q[0].win || (sense_conn_o === 8'h00 && sense_q !== 8'h00))) begin
        n = q.pop_front();
        if (n.win) begin
          chk("period ticks", n.per, (per + 12) / TK);
          chk("window ticks", 32'(POLL), (cyc - t_rise + 12) / TK);
        end else begin
          sense_acc = sense_conn_o;
          wet_acc = wet_drive_o;
        end
        chk("sense", n.sense, sense_acc);
        chk("wetting", n.wet, wet_acc);
        chk("switch state", n.sw, sw_state_o);
        chk("mode", n.mode, mode_o);
        chk("direct enables", {2{n.dout[2]}}, {oe_a, oe_b});
        if (n.dout[2]) chk("direct out", n.dout[1:0], {out_b, out_a});
        chk("float", n.hiz, input_hiz_o);
        chk("command", n.cmd, cmd_o);
      end
      sense_q = sense_conn_o;
    end
  end

  initial begin
    repeat (90000) @(posedge sys_clk_i);
    failures++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    falls(2);
    note(1'b1, 32'(BASE) << 5, ST_SCAN, 3'h0, 1'b0, 8'hfc, 8'h00);
    for (int c = 0; c < 6; c++) begin
      cmd = swsc_cmd_type'(16'($random(seed)));
      cmd.scan_period = 3'(c);
      cmd.wetting_continuous_sel = 1'b1;
      cmd.wetting_global_en = 1'b1;
      cmd.low_pair_wetting_en = 1'b1;
      closed <= 8'($random(seed));
      wr(cmd);
      falls(2);
      note(1'b1, 32'(BASE) << (5 - c), ST_SCAN, 3'h0, 1'b0, 8'hff, closed);
    end
    cmd = CMD_RESET;
    cmd.scan_period = 3'h5;
    cmd.wetting_global_en = 1'b1;
    closed <= 8'h00;
    wr(cmd);
    falls(2);
    closed <= 8'($random(seed)) | 8'h04;
    falls(1);
    note(1'b1, 32'(BASE), ST_SCAN, 3'h0, 1'b0, 8'hfc, closed & 8'hfc);
    falls(2);
    note(1'b1, 32'(BASE), ST_SCAN, 3'h0, 1'b0, 8'hfc, 8'h00);
    for (int c = 6; c < 8; c++) begin
      cmd = CMD_RESET;
      cmd.scan_period = 3'(c);
      cmd.wetting_continuous_sel = 1'b1;
      cmd.wetting_global_en = 1'b1;
      wr(cmd);
      repeat (10) @(posedge sys_clk_i);
      note(1'b0, 32'h0, ST_NORMAL, {1'b1, closed[1:0]}, 1'b0, 8'hfc, closed & 8'hfc);
    end
    cmd.scan_period = 3'h3;
    wr(cmd);
    falls(2);
    note(1'b1, 32'(BASE) << 2, ST_SCAN, 3'h0, 1'b0, 8'hfc, closed & 8'hfc);
    sleep <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    wr(swsc_cmd_type'(16'($random(seed))));
    cmd_now = CMD_RESET;
    note(1'b0, 32'h0, ST_SHDN, 3'h0, 1'b1, 8'h00, 8'h00);
    sleep <= 1'b0;
    for (len = 0; len < 100 && mode_o !== ST_WAKE; len++) @(posedge sys_clk_i);
    for (len = 0; len < 400 && mode_o !== ST_SCAN; len++) @(posedge sys_clk_i);
    chk("exit delay", 32'h1, 32'(len >= int'(EXIT - 1) * TK && len <= int'(EXIT + 1) * TK));
    falls(2);
    note(1'b1, 32'(BASE) << 5, ST_SCAN, 3'h0, 1'b0, 8'hfc, 8'h00);
    print_verdict();
  end
endmodule

`default_nettype wire
